// ### logic/tws_pkg.sv
// Shared constants and state encoding for the two-wire memory slave
package tws_pkg;

  // Core clock rate and internal programming time
  localparam int CLK_MHZ      = 200;                    // Core clock, MHz
  localparam int PROG_TIME_US = 5000;                   // Programming time, us
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ; // Programming time, cycles

  // Frame layout and reset values
  localparam logic [2:0] BIT_LAST   = 3'h7;  // Index of last bit in a byte
  localparam logic [2:0] BIT_FIRST  = 3'h0;  // Bit counter after a byte
  localparam logic [7:0] ADDR_RST   = 8'h00; // Address counter after reset
  localparam logic [7:0] BYTE_RST   = 8'h00; // Shift and data registers after reset
  localparam int         TYPE_MSB   = 7;     // Device-type field, top bit
  localparam int         TYPE_LSB   = 4;     // Device-type field, low bit
  localparam int         SEL_MSB    = 3;     // Select field, top bit
  localparam int         SEL_LSB    = 1;     // Select field, low bit
  localparam int         DIR_BIT    = 0;     // Direction bit, one means read

  // Protocol states of the slave
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0, // Waiting for a start
    ST_DEV_ADDR  = 4'h1, // Receiving slave address
    ST_ACK_DEV   = 4'h2, // Acknowledging slave address
    ST_WORD_ADDR = 4'h3, // Receiving word address
    ST_ACK_WORD  = 4'h4, // Acknowledging word address
    ST_WR_DATA   = 4'h5, // Receiving data byte
    ST_ACK_DATA  = 4'h6, // Acknowledging data byte
    ST_RD_DATA   = 4'h7, // Sending data byte
    ST_RD_ACK    = 4'h8, // Sampling master acknowledge
    ST_WAIT_STOP = 4'h9, // Released, waiting for start or stop
    ST_PROG      = 4'ha  // Internal programming, deaf to the bus
  } tws_state_e;

endpackage : tws_pkg

// ### logic/tws_line_if.sv
// Carrier of cleaned bus line events from the line monitor to the core
`timescale 1ns/1ps
interface tws_line_if;
  logic       scl_lvl;  // Synchronised clock line level
  logic       sda_lvl;  // Synchronised data line level
  logic       scl_fall; // Clock line fell, one-cycle pulse
  logic       start;    // Start condition, one-cycle pulse
  logic       stop;     // Stop condition, one-cycle pulse
  logic       bit_stb;  // New bit captured on a rising clock, pulse
  logic       bit_val;  // Value of the captured bit
  logic [2:0] sel;      // Synchronised select pins

  modport mon  (output scl_lvl, sda_lvl, scl_fall, start, stop, bit_stb, bit_val, sel);
  modport core (input  scl_lvl, sda_lvl, scl_fall, start, stop, bit_stb, bit_val, sel);
endinterface : tws_line_if

// ### logic/tws_line_mon.sv
// Bus line monitor: bit capture on the link clock, synchronisers, start and stop
`timescale 1ns/1ps
module tws_line_mon (
  input  wire logic       clk,     // Core clock
  input  wire logic       nrst,    // Reset, active low
  input  wire logic       scl,     // Link clock from the master
  input  wire logic       sda_in,  // Data line level
  input  wire logic [2:0] sel_pin, // Select pins
  tws_line_if.mon         line     // Events towards the core
);

  // Link domain: capture bit and flip toggle on each rising link clock
  logic cap_tgl_ff; // Toggles once per captured bit
  logic cap_val_ff; // Captured data bit, held until next rise

  // Core domain synchronisers; first stages read only by second stages
  logic scl_m_ff, scl_s_ff, scl_d_ff; // Clock line stages
  logic sda_m_ff, sda_s_ff, sda_d_ff; // Data line stages
  logic tgl_m_ff, tgl_s_ff, tgl_d_ff; // Toggle stages
  logic [2:0] sel_m_ff, sel_s_ff;     // Select pin stages

  // Link clock may stop at any time, so reset must not wait for its edge
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      cap_tgl_ff <= 1'b0;
      cap_val_ff <= 1'b0;
    end else begin
      cap_tgl_ff <= ~cap_tgl_ff;
      cap_val_ff <= sda_in;
    end
  end

  // Two-flop synchronisers plus one delay stage for edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
      {tgl_m_ff, tgl_s_ff, tgl_d_ff} <= 3'h0;
      sel_m_ff <= 3'h0;
      sel_s_ff <= 3'h0;
    end else begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_m_ff, sda_s_ff};
      {tgl_m_ff, tgl_s_ff, tgl_d_ff} <= {cap_tgl_ff, tgl_m_ff, tgl_s_ff};
      sel_m_ff <= sel_pin;
      sel_s_ff <= sel_m_ff;
    end
  end

  // Data edges while clock stays high mark start and stop
  wire scl_high_w = scl_s_ff & scl_d_ff;
  assign line.scl_lvl  = scl_s_ff;
  assign line.sda_lvl  = sda_s_ff;
  assign line.scl_fall = scl_d_ff & ~scl_s_ff;
  assign line.start    = scl_high_w & sda_d_ff & ~sda_s_ff;
  assign line.stop     = scl_high_w & ~sda_d_ff & sda_s_ff;
  assign line.bit_stb  = tgl_s_ff ^ tgl_d_ff;
  // Captured bit is stable for a whole link period after its toggle
  assign line.bit_val  = cap_val_ff;
  assign line.sel      = sel_s_ff;

endmodule : tws_line_mon

// ### logic/tws_eeprom_slave.sv
// Two-wire slave of a 256 x 8 nonvolatile memory with self-timed byte write
// Behaviour
// - Data changes only while clock is low
// - Data falling with clock high is start
// - Ignore all activity until a start
// - Data rising with clock high is stop
// - Stop after read returns to standby
// - Release after eight bits, ninth acknowledges
// - Top four address bits match type code
// - Next three bits match select pins
// - Last address bit one reads, zero writes
// - Acknowledge matching address, then read or write
// - Acknowledge every further byte of a write
// - Read sends byte, continues on acknowledge
// - No acknowledge ends read data output
// - Write carries eight-bit word address
// - Acknowledge word address and one data byte
// - Stop after data byte starts programming
// - Programming ignores inputs, no response
// - Programming self-timed, five milliseconds
// - Address counter holds last location plus one
`timescale 1ns/1ps
module tws_eeprom_slave #(
  parameter logic [3:0] DEV_TYPE_CODE = 4'h5,  // Arbitrary device-type code
  parameter int         PROG_CYCLES   = tws_pkg::PROG_CYCLES, // Programming cycles
  parameter int         MEM_DEPTH     = 256    // Memory locations
) (
  input  wire logic clk,              // Core clock, 200 MHz
  input  wire logic nrst,             // Reset, active low; synchronous except for the link-clock capture flops
  input  wire logic scl,              // Link clock from the master
  input  wire logic sda_in,           // Data line level
  output wire logic sda_out,          // Data line drive value
  output wire logic sda_oe_n,         // Data line drive enable, active low
  input  wire logic addr_select_bit0, // Select pin 0
  input  wire logic addr_select_bit1, // Select pin 1
  input  wire logic addr_select_bit2, // Select pin 2
  output wire logic prog_busy,        // Internal programming running
  output wire logic standby           // Device in standby
);

  localparam int TW = $clog2(PROG_CYCLES + 1); // Timer width

  // Carrier from the line monitor
  tws_line_if line_if ();

  // Line monitor: synchronisers, bit capture on link clock, start and stop
  tws_line_mon u_mon (
    .clk     (clk),
    .nrst    (nrst),
    .scl     (scl),
    .sda_in  (sda_in),
    .sel_pin ({addr_select_bit2, addr_select_bit1, addr_select_bit0}),
    .line    (line_if.mon)
  );

  // Memory array, no reset: contents survive core reset
  logic [7:0] mem [MEM_DEPTH];

  // State registers and their next values
  tws_pkg::tws_state_e state_ff, nxt_state; // Protocol state
  logic [2:0]    cnt_ff,      nxt_cnt;      // Bit counter within a byte
  logic [7:0]    rx_ff,       nxt_rx;       // Receive shift register
  logic [7:0]    tx_ff,       nxt_tx;       // Transmit shift register
  logic [7:0]    ctr_ff,      nxt_ctr;      // Address counter
  logic [7:0]    wdata_ff,    nxt_wdata;    // Data byte waiting for programming
  logic          rw_ff,       nxt_rw;       // Direction of current transfer
  logic          ack_done_ff, nxt_ack_done; // Ninth clock seen in ack state
  logic          wr_have_ff,  nxt_wr_have;  // Data byte received this write
  logic          load_ff,     nxt_load;     // Load next read byte on next fall
  logic          drv_low_ff,  nxt_drv_low;  // Pull the data line low
  logic          stby_ff,     nxt_stby;     // Standby flag
  logic [TW-1:0] tmr_ff;                    // Programming countdown

  // Decode of line events and state
  wire [7:0] rx_next_w   = {rx_ff[6:0], line_if.bit_val}; // Byte with new bit
  wire       last_bit_w  = (cnt_ff == tws_pkg::BIT_LAST); // Eighth bit
  wire       type_ok_w   = rx_next_w[tws_pkg::TYPE_MSB:tws_pkg::TYPE_LSB] == DEV_TYPE_CODE;
  wire       sel_ok_w    = rx_next_w[tws_pkg::SEL_MSB:tws_pkg::SEL_LSB] == line_if.sel;
  wire       match_w     = type_ok_w & sel_ok_w;          // Address match
  wire       busy_w      = (state_ff == tws_pkg::ST_PROG); // Programming
  wire       tmr_zero_w  = (tmr_ff == '0);                 // Countdown end
  wire [7:0] mem_rd_w    = mem[ctr_ff];                    // Byte at counter
  wire [7:0] ctr_inc_w   = ctr_ff + 8'h01;                 // Counter plus one
  wire [7:0] tx_shift_w  = {tx_ff[6:0], 1'b0};             // Next bit to send
  wire       in_ack_w    = (state_ff == tws_pkg::ST_ACK_DEV)  |
                           (state_ff == tws_pkg::ST_ACK_WORD) |
                           (state_ff == tws_pkg::ST_ACK_DATA);
  // Stop after a received data byte launches programming
  wire       prog_go_w   = ~busy_w & ~line_if.start & line_if.stop & wr_have_ff;

  // Next-state logic; while programming only the timer matters
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_rx       = rx_ff;
    nxt_tx       = tx_ff;
    nxt_ctr      = ctr_ff;
    nxt_wdata    = wdata_ff;
    nxt_rw       = rw_ff;
    nxt_ack_done = ack_done_ff;
    nxt_wr_have  = wr_have_ff;
    nxt_load     = load_ff;
    nxt_drv_low  = drv_low_ff;
    nxt_stby     = stby_ff;
    if (busy_w) begin
      // Deaf to the bus until the countdown ends
      if (tmr_zero_w) begin
        nxt_state = tws_pkg::ST_IDLE;
        nxt_stby  = 1'b1;
      end
    end else if (line_if.start) begin
      // Start restarts address reception in every state except programming
      nxt_state    = tws_pkg::ST_DEV_ADDR;
      nxt_cnt      = tws_pkg::BIT_FIRST;
      nxt_ack_done = 1'b0;
      nxt_wr_have  = 1'b0;
      nxt_load     = 1'b0;
      nxt_drv_low  = 1'b0;
      nxt_stby     = 1'b0;
    end else if (line_if.stop) begin
      // Stop ends the transfer; a pending byte goes to the array
      nxt_drv_low = 1'b0;
      nxt_load    = 1'b0;
      if (wr_have_ff) begin
        nxt_state   = tws_pkg::ST_PROG;
        nxt_ctr     = ctr_inc_w;
        nxt_wr_have = 1'b0;
      end else begin
        nxt_state = tws_pkg::ST_IDLE;
        nxt_stby  = 1'b1;
      end
    end else if (line_if.bit_stb) begin
      // Rising link clock delivered a bit
      case (state_ff)
        tws_pkg::ST_DEV_ADDR: begin
          nxt_rx  = rx_next_w;
          nxt_cnt = cnt_ff + 3'h1;
          if (last_bit_w) begin
            if (match_w) begin
              nxt_state = tws_pkg::ST_ACK_DEV;
              nxt_rw    = rx_next_w[tws_pkg::DIR_BIT];
            end else begin
              nxt_state = tws_pkg::ST_WAIT_STOP;
            end
          end
        end
        tws_pkg::ST_WORD_ADDR: begin
          nxt_rx  = rx_next_w;
          nxt_cnt = cnt_ff + 3'h1;
          if (last_bit_w) begin
            nxt_ctr   = rx_next_w;
            nxt_state = tws_pkg::ST_ACK_WORD;
          end
        end
        tws_pkg::ST_WR_DATA: begin
          nxt_rx  = rx_next_w;
          nxt_cnt = cnt_ff + 3'h1;
          if (last_bit_w) begin
            nxt_wdata   = rx_next_w;
            nxt_wr_have = 1'b1;
            nxt_state   = tws_pkg::ST_ACK_DATA;
          end
        end
        tws_pkg::ST_ACK_DEV, tws_pkg::ST_ACK_WORD, tws_pkg::ST_ACK_DATA: begin
          // Ninth clock high: acknowledge is on the line
          nxt_ack_done = 1'b1;
        end
        tws_pkg::ST_RD_DATA: begin
          nxt_cnt = cnt_ff + 3'h1;
          if (last_bit_w) begin
            nxt_state = tws_pkg::ST_RD_ACK;
          end
        end
        tws_pkg::ST_RD_ACK: begin
          // Master acknowledge decides whether another byte follows
          if (line_if.bit_val) begin
            nxt_state = tws_pkg::ST_WAIT_STOP;
          end else begin
            nxt_state = tws_pkg::ST_RD_DATA;
            nxt_cnt   = tws_pkg::BIT_FIRST;
            nxt_load  = 1'b1;
          end
        end
        default: begin
          // Idle and waiting states ignore bits
        end
      endcase
    end else if (line_if.scl_fall) begin
      // Clock low: the only time the data line may change
      case (state_ff)
        tws_pkg::ST_ACK_DEV, tws_pkg::ST_ACK_WORD, tws_pkg::ST_ACK_DATA: begin
          if (!ack_done_ff) begin
            nxt_drv_low = 1'b1;
          end else begin
            nxt_drv_low  = 1'b0;
            nxt_ack_done = 1'b0;
            nxt_cnt      = tws_pkg::BIT_FIRST;
            if (state_ff == tws_pkg::ST_ACK_DEV && rw_ff) begin
              // Read begins at the address counter
              nxt_state   = tws_pkg::ST_RD_DATA;
              nxt_tx      = mem_rd_w;
              nxt_drv_low = ~mem_rd_w[7];
              nxt_ctr     = ctr_inc_w;
            end else if (state_ff == tws_pkg::ST_ACK_DEV) begin
              nxt_state = tws_pkg::ST_WORD_ADDR;
            end else begin
              nxt_state = tws_pkg::ST_WR_DATA;
            end
          end
        end
        tws_pkg::ST_RD_DATA: begin
          if (load_ff) begin
            nxt_tx      = mem_rd_w;
            nxt_drv_low = ~mem_rd_w[7];
            nxt_ctr     = ctr_inc_w;
            nxt_load    = 1'b0;
          end else if (cnt_ff != tws_pkg::BIT_FIRST) begin
            nxt_tx      = tx_shift_w;
            nxt_drv_low = ~tx_shift_w[7];
          end
        end
        tws_pkg::ST_RD_ACK: begin
          // Release the line for the master acknowledge
          nxt_drv_low = 1'b0;
        end
        default: begin
          nxt_drv_low = 1'b0;
        end
      endcase
    end
  end

  // Protocol state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= tws_pkg::ST_IDLE;
      cnt_ff   <= tws_pkg::BIT_FIRST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Shift registers and address counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_ff    <= tws_pkg::BYTE_RST;
      tx_ff    <= tws_pkg::BYTE_RST;
      ctr_ff   <= tws_pkg::ADDR_RST;
      wdata_ff <= tws_pkg::BYTE_RST;
    end else begin
      rx_ff    <= nxt_rx;
      tx_ff    <= nxt_tx;
      ctr_ff   <= nxt_ctr;
      wdata_ff <= nxt_wdata;
    end
  end

  // Transfer flags and line drive
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {rw_ff, ack_done_ff, wr_have_ff, load_ff} <= 4'h0;
      drv_low_ff <= 1'b0;
      stby_ff    <= 1'b1;
    end else begin
      {rw_ff, ack_done_ff, wr_have_ff, load_ff} <= {nxt_rw, nxt_ack_done, nxt_wr_have, nxt_load};
      drv_low_ff <= nxt_drv_low;
      stby_ff    <= nxt_stby;
    end
  end

  // Self-timed countdown, loaded as programming starts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tmr_ff <= '0;
    end else if (prog_go_w) begin
      tmr_ff <= TW'(PROG_CYCLES - 1);
    end else if (busy_w && !tmr_zero_w) begin
      tmr_ff <= tmr_ff - TW'(1);
    end
  end

  // Array write at programming start
  always_ff @(posedge clk) begin
    if (prog_go_w) begin
      mem[ctr_ff] <= wdata_ff;
    end
  end

  // Open-drain pin: only ever pulls low
  assign sda_out   = 1'b0;
  assign sda_oe_n  = ~drv_low_ff;
  assign prog_busy = busy_w;
  assign standby   = stby_ff;

  // Checks on protocol behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  int unsigned prog_len; // Cycles spent in programming
  always_ff @(posedge clk) begin
    if (!nrst || !busy_w) begin
      prog_len <= 0;
    end else begin
      prog_len <= prog_len + 1;
    end
  end

  // Start of programming seen as busy with line released
  sequence s_prog_entry;
    (state_ff == tws_pkg::ST_PROG) && sda_oe_n;
  endsequence

  // Last address bit arrives
  sequence s_addr_done;
    (state_ff == tws_pkg::ST_DEV_ADDR) && line_if.bit_stb && last_bit_w && !line_if.start &&
      !line_if.stop;
  endsequence

  a_start_restart: assert property (line_if.start && !busy_w |=>
    state_ff == tws_pkg::ST_DEV_ADDR && cnt_ff == tws_pkg::BIT_FIRST)
    else $error("start did not restart address reception");

  a_idle_ignores: assert property ((state_ff == tws_pkg::ST_IDLE) && !line_if.start |=>
    state_ff == tws_pkg::ST_IDLE)
    else $error("idle slave reacted without start");

  a_addr_match: assert property (s_addr_done |=>
    (state_ff == tws_pkg::ST_ACK_DEV) == $past(match_w))
    else $error("address match did not select the slave");

  a_nomatch_quiet: assert property (s_addr_done and !match_w |=>
    (state_ff == tws_pkg::ST_WAIT_STOP && sda_oe_n) [*3])
    else $error("mismatched slave touched the line");

  a_ack_drive: assert property (in_ack_w && !ack_done_ff && line_if.scl_fall && !line_if.start &&
    !line_if.stop |=> !sda_oe_n)
    else $error("acknowledge not driven low");

  a_line_scl_low: assert property ($changed(sda_oe_n) && !$past(line_if.stop) &&
    !$past(line_if.start) |-> !line_if.scl_lvl)
    else $error("data line changed while clock high");

  a_stop_prog: assert property (prog_go_w |=> s_prog_entry ##1 prog_busy)
    else $error("stop after data did not start programming");

  a_prog_deaf: assert property (busy_w && !tmr_zero_w |=> busy_w && sda_oe_n)
    else $error("slave responded during programming");

  a_prog_time: assert property (busy_w && tmr_zero_w |->
    prog_len == PROG_CYCLES - 1 ##1 !busy_w)
    else $error("programming time wrong");

  a_rd_nack: assert property ((state_ff == tws_pkg::ST_RD_ACK) && line_if.bit_stb &&
    line_if.bit_val && !line_if.start && !line_if.stop |=>
    state_ff == tws_pkg::ST_WAIT_STOP && sda_oe_n)
    else $error("read continued without acknowledge");

  a_stop_standby: assert property (line_if.stop && !busy_w && !line_if.start &&
    !wr_have_ff |=> standby && state_ff == tws_pkg::ST_IDLE)
    else $error("stop did not return to standby");

  a_ctr_step: assert property (prog_go_w |=> ctr_ff == $past(ctr_ff) + 8'h01)
    else $error("address counter not advanced after write");

endmodule : tws_eeprom_slave

// ### tb/tws_mst_model.sv
// Two-wire bus master model: drives the link clock and the data line
`timescale 1ns/1ps
module tws_mst_model (
  output logic      scl,   // Link clock, high and still between frames
  output logic      sda_m, // Master drive, high releases
  input  wire logic sda    // Resolved line level
);
  // Bus idle until the first frame
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  // One clock: 30 ns low, 18 ns high, sample at the rise
  task automatic bit_io(input logic b, output logic r);
    #6 sda_m = b;
    #24 scl = 1'h1;
    r = sda;
    #18 scl = 1'h0;
  endtask : bit_io
  // Start, also usable as a repeated start
  task automatic start();
    #6 sda_m = 1'h1;
    #24 scl = 1'h1;
    #40 sda_m = 1'h0;
    #40 scl = 1'h0;
  endtask : start
  // Stop, issued once the slave has let go
  task automatic stop();
    #6 sda_m = 1'h0;
    #24 scl = 1'h1;
    #40 sda_m = 1'h1;
    #40;
  endtask : stop
  // Byte out MSB first, then sample the ninth clock
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) mst_bit(b[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask : send
  // Short alias for one data clock
  task automatic mst_bit(input logic b, output logic r);
    bit_io(b, r);
  endtask : mst_bit
  // Byte in MSB first, then acknowledge or withhold it
  task automatic recv(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      b[i] = r;
    end
    bit_io(~ack, r);
  endtask : recv
endmodule : tws_mst_model

// ### tb/two_wire_eeprom_slave_tb_top.sv
// Self-checking bench of the two-wire memory slave
`timescale 1ns/1ps
module two_wire_eeprom_slave_tb_top;
  localparam int         PROG = 300;                // Short programming time
  localparam logic [3:0] TYPE = 4'h9;               // Type code, arbitrary
  localparam logic [2:0] SEL  = 3'h5;               // Select strap
  localparam logic [7:0] DW   = {TYPE, SEL, 1'h0};  // Write address byte
  localparam logic [7:0] DR   = {TYPE, SEL, 1'h1};  // Read address byte
  logic       clk          = 1'h0;  // Core clock
  logic       nrst;                 // Reset, active low, falls at 1 ns
  logic [2:0] sel          = SEL;   // Select pins
  logic       a;                    // Acknowledge seen
  logic [7:0] d;                    // Byte read
  int         busy_n       = 0;     // Programming cycles seen
  int         fail_count   = 0;     // Mismatches
  int         total_checks = 0;     // Comparisons
  wire        scl;                  // Link clock
  wire        sda_m;                // Master drive
  wire        sda_out;              // Device drive value
  wire        sda_oe_n;             // Device drive enable
  wire        prog_busy;            // Programming flag
  wire        standby;              // Standby flag
  wire        sda = (sda_oe_n ? 1'h1 : sda_out) & sda_m; // Line with pull-up

  // 200 MHz core clock
  always #2.5 clk = ~clk;
  // Count programming cycles
  always @(negedge clk) if (prog_busy === 1'h1) busy_n++;

  tws_eeprom_slave #(.DEV_TYPE_CODE(TYPE), .PROG_CYCLES(PROG)) dut (
    .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .addr_select_bit2(sel[2]), .prog_busy(prog_busy), .standby(standby));
  tws_mst_model mst (.scl(scl), .sda_m(sda_m), .sda(sda));

  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Send a byte and judge its acknowledge
  task automatic tx(input logic [7:0] b, input logic e, input string n);
    mst.send(b, a);
    chk(n, e, a);
  endtask : tx
  // Byte write, deaf check, programming time
  task automatic wr(input logic [7:0] w, input logic [7:0] v);
    busy_n = 0;
    mst.start();
    tx(DW, 1'h1, "ack dev");
    tx(w, 1'h1, "ack word");
    tx(v, 1'h1, "ack data");
    mst.stop();
    chk("busy", 2'h2, {prog_busy, standby});
    mst.start();
    tx(DW, 1'h0, "deaf");
    mst.stop();
    for (int i = 0; i < 2 * PROG && prog_busy !== 1'h0; i++) @(negedge clk);
    chk("prog len", 1'h1, busy_n >= PROG && busy_n <= PROG + 1);
    chk("idle", 1'h1, standby);
    $display("write done");
  endtask : wr
  // Frame with no start: first clock only lowers the idle-high link clock
  task automatic t_nostart();
    mst.bit_io(1'h1, a);
    tx(DW, 1'h0, "no start");
    mst.stop();
    $display("no start done");
  endtask : t_nostart
  // Repeated start in mid-address restarts reception
  task automatic t_restart();
    mst.start();
    for (int i = 0; i < 4; i++) mst.bit_io(1'h1, a);
    mst.start();
    tx(DW, 1'h1, "restart");
    mst.stop();
    $display("restart done");
  endtask : t_restart
  // Reads: current address, random, wrap, after refusal
  task automatic t_read();
    mst.start();
    tx(DR, 1'h1, "ack rd");
    mst.recv(1'h0, d);
    chk("cur rd", 8'h3c, d);
    mst.stop();
    chk("standby", 1'h1, standby);
    mst.start();
    tx(DW, 1'h1, "ack dummy");
    tx(8'hff, 1'h1, "ack word");
    mst.start();
    tx(DR, 1'h1, "ack rd");
    mst.recv(1'h1, d);
    chk("rand rd", 8'ha5, d);
    mst.recv(1'h0, d);
    chk("wrap rd", 8'h3c, d);
    mst.recv(1'h0, d);
    chk("released", 8'hff, d);
    mst.stop();
    $display("read done");
  endtask : t_read
  // Select pins and type code matching
  task automatic t_sel();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      sel = i[2:0];
      mst.start();
      tx(DW, i == SEL, "sel");
      mst.stop();
    end
    @(negedge clk);
    sel = SEL;
    mst.start();
    tx({~TYPE, SEL, 1'h0}, 1'h0, "type");
    mst.stop();
    $display("select done");
  endtask : t_sel
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    // Reset falls after time zero so the link-clock flops see a real edge
    #1 nrst = 1'h0;
    repeat (2) @(negedge clk);
    chk("reset", 3'h5, {sda_oe_n, prog_busy, standby});
    nrst = 1'h1;
    repeat (4) @(negedge clk);
    t_nostart();
    wr(8'h00, 8'h3c);
    wr(8'hff, 8'ha5);
    t_read();
    t_sel();
    t_restart();
    test_done();
  end
  // Watchdog against a hang
  initial begin
    #200us;
    fail_count++;
    test_done();
  end
endmodule : two_wire_eeprom_slave_tb_top
